// ---- rtl/ecd_defines.vh ----
// Function
// - Exponent zero means plain transfer ring
// - Nonzero exponent means primary stream array
// - Exponent N gives N+1 bit IDs
// - Linear flag: whole ID indexes primary
// - Flag clear: split ID, exponent 1..7
// - Period is 125 us times 2^interval; code caps interval at 16
// - Payload high byte used when capability set
// - Retry limit is consecutive error down count
// - Load counter per transaction, decrement on failure
// - Counter 1 to 0 halts, posts error
// - Zero limit means unlimited retries
// - Endpoint kind decides validity and type
// - Burst multiplier needs no burst of 16; code stores it and never checks it
// - State codes disabled..error, 5-7 reserved
// - Kind codes 0 invalid through 5 iso-in
`ifndef ECD_DEFINES_VH
`define ECD_DEFINES_VH

// Register byte addresses.
`define ECD_ADDR_DW0 12'h000
`define ECD_ADDR_DW1 12'h004
`define ECD_ADDR_CTRL 12'h008
`define ECD_ADDR_STREAM 12'h00C
`define ECD_ADDR_STATUS 12'h010
`define ECD_ADDR_PERIOD 12'h014
`define ECD_ADDR_ARRAY 12'h018

// Context word 0 field positions.
`define ECD_STATE_LO 0
`define ECD_STATE_HI 2
`define ECD_MULT_LO 8
`define ECD_MULT_HI 9
`define ECD_PSTR_LO 10
`define ECD_PSTR_HI 14
`define ECD_LSA_BIT 15
`define ECD_IVAL_LO 16
`define ECD_IVAL_HI 23
`define ECD_PLHI_LO 24
`define ECD_PLHI_HI 31

// Context word 1 field positions.
`define ECD_ERROR_RETRY_LIMIT_LO 1
`define ECD_ERROR_RETRY_LIMIT_HI 2
`define ECD_KIND_LO 3
`define ECD_KIND_HI 5

// Endpoint state codes.
`define ECD_ST_DISABLED 3'h0
`define ECD_ST_RUNNING 3'h1
`define ECD_ST_HALTED 3'h2
`define ECD_ST_STOPPED 3'h3
`define ECD_ST_ERROR 3'h4

// Endpoint kind codes.
`define ECD_KIND_INVALID 3'h0
`define ECD_KIND_ISO_OUT 3'h1
`define ECD_KIND_BULK_OUT 3'h2
`define ECD_KIND_INT_OUT 3'h3
`define ECD_KIND_CONTROL 3'h4
`define ECD_KIND_ISO_IN 3'h5

// Reset values and limits.
`define ECD_RESET_WORD 32'h0000_0000
`define ECD_SPLIT_MAX_EXP 5'h07
`define ECD_LINEAR_MAX_EXP 5'h0F

// Base service period and its cycle count at 100 MHz.
`define ECD_BASE_PERIOD_NS 125000
`define ECD_CLK_PERIOD_NS 10
`define ECD_BASE_PERIOD_CYC (`ECD_BASE_PERIOD_NS / `ECD_CLK_PERIOD_NS)

`endif

// ---- rtl/ecd_interval_timer.v ----
`timescale 1ns/1ps
`include "ecd_defines.vh"

// Periodic service tick generator: one pulse every BASE * 2^interval cycles, with interval capped at 16.
module ecd_interval_timer #(
  parameter BASE_CYC = `ECD_BASE_PERIOD_CYC
) (
  // Clock and control.
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  input wire enable,
  // Interval exponent.
  input wire [7:0] interval,
  // Outputs.
  output reg tick,
  output reg [15:0] slot_count
);

  localparam [31:0] BASE_M1 = BASE_CYC - 1;

  reg [31:0] base_reg;
  reg [15:0] slot_target;

  // Slot count limit is 2^interval - 1; exponents past 15 saturate.
  always @* begin
    if (interval > 8'h0F) begin
      slot_target = 16'hFFFF;
    end else begin
      slot_target = (16'h0001 << interval[3:0]) - 16'h0001;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      base_reg <= 32'h0000_0000;
      slot_count <= 16'h0000;
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= 1'b0;
      if (!enable) begin
        base_reg <= 32'h0000_0000;
        slot_count <= 16'h0000;
      end else if (base_reg == BASE_M1) begin
        base_reg <= 32'h0000_0000;
        if (slot_count >= slot_target) begin
          slot_count <= 16'h0000;
          tick <= 1'b1;
        end else begin
          slot_count <= slot_count + 16'h0001;
        end
      end else begin
        base_reg <= base_reg + 32'h0000_0001;
      end
    end
  end

endmodule

// ---- rtl/ecd_top.v ----
`timescale 1ns/1ps
`include "ecd_defines.vh"

// Endpoint context field decoder with AHB-Lite register access.
module ecd_top #(
  parameter BASE_CYC = `ECD_BASE_PERIOD_CYC
) (
  // Clock, reset and enable.
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  // AHB-Lite slave.
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Transaction status from the bus engine.
  input wire txn_start,
  input wire txn_fail,
  input wire txn_ok,
  // Decoded results.
  output reg streams_enabled,
  output reg [4:0] stream_id_width,
  output reg [4:0] primary_index_width,
  output reg [15:0] primary_index,
  output reg [15:0] secondary_index,
  output reg [16:0] primary_entries,
  output reg [2:0] endpoint_state_field,
  output reg [2:0] endpoint_kind,
  output reg context_valid,
  output reg config_error,
  output reg [7:0] service_interval_payload_high,
  output wire service_tick,
  output reg trb_abort,
  output reg transaction_error_event
);

  // Context words, control, stream id and error counter.
  reg [31:0] dw0_reg;
  reg [31:0] dw1_reg;
  reg [1:0] ctrl_reg;
  reg [15:0] stream_reg;
  reg [1:0] bus_err_reg;
  reg [1:0] bus_err_next;
  reg [2:0] state_next;
  reg halt_pulse;
  // Captured address phase.
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;
  reg [31:0] rd_next;
  wire [15:0] slot_count;

  // Field views of the context words and the control register.
  wire [4:0] pstr_exp = dw0_reg[`ECD_PSTR_HI:`ECD_PSTR_LO];
  wire lsa_flag = dw0_reg[`ECD_LSA_BIT];
  wire [7:0] interval = dw0_reg[`ECD_IVAL_HI:`ECD_IVAL_LO];
  wire [1:0] error_retry_limit = dw1_reg[`ECD_ERROR_RETRY_LIMIT_HI:`ECD_ERROR_RETRY_LIMIT_LO];
  wire [2:0] kind_raw = dw1_reg[`ECD_KIND_HI:`ECD_KIND_LO];
  wire large_service_interval_capability = ctrl_reg[0];
  wire ep_run = ctrl_reg[1];

  // The slave never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire addr_phase = hsel & htrans[1] & hready;

  // Read mux; unmapped addresses read as zero.
  always @* begin
    case (haddr)
      `ECD_ADDR_DW0: rd_next = dw0_reg;
      `ECD_ADDR_DW1: rd_next = dw1_reg;
      `ECD_ADDR_CTRL: rd_next = {30'h0000_0000, ctrl_reg};
      `ECD_ADDR_STREAM: rd_next = {16'h0000, stream_reg};
      `ECD_ADDR_STATUS: rd_next = {21'h00_0000, context_valid,
        config_error, streams_enabled, bus_err_reg, endpoint_kind,
        endpoint_state_field};
      `ECD_ADDR_PERIOD: rd_next = {16'h0000, slot_count};
      `ECD_ADDR_ARRAY: rd_next = {10'h000, primary_index_width,
        primary_entries};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // Bus error counter next value and halt detection.
  always @* begin
    bus_err_next = bus_err_reg;
    halt_pulse = 1'b0;
    if (txn_start && error_retry_limit != 2'b00) begin
      bus_err_next = error_retry_limit;
    end
    if (txn_fail && error_retry_limit != 2'b00) begin
      if (bus_err_next == 2'b01) begin
        halt_pulse = 1'b1;
      end
      if (bus_err_next != 2'b00) begin
        bus_err_next = bus_err_next - 2'b01;
      end
    end
  end

  // Endpoint state: run enable, halt on exhausted retries.
  always @* begin
    state_next = dw0_reg[`ECD_STATE_HI:`ECD_STATE_LO];
    if (halt_pulse && state_next == `ECD_ST_RUNNING) begin
      state_next = `ECD_ST_HALTED;
    end else if (ep_run && state_next == `ECD_ST_DISABLED &&
        context_valid) begin
      state_next = `ECD_ST_RUNNING;
    end else if (!ep_run && state_next == `ECD_ST_RUNNING) begin
      state_next = `ECD_ST_STOPPED;
    end
  end

  // Register writes, data phase after the captured address phase.
  always @(posedge sys_clk) begin
    if (reset) begin
      dw0_reg <= `ECD_RESET_WORD;
      dw1_reg <= `ECD_RESET_WORD;
      ctrl_reg <= 2'b00;
      stream_reg <= 16'h0000;
      bus_err_reg <= 2'b00;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata <= 32'h0000_0000;
      trb_abort <= 1'b0;
      transaction_error_event <= 1'b0;
    end else if (clk_en) begin
      wr_pend_reg <= addr_phase & hwrite;
      wr_addr_reg <= haddr;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_next;
      end
      bus_err_reg <= bus_err_next;
      trb_abort <= halt_pulse;
      transaction_error_event <= halt_pulse;
      dw0_reg[`ECD_STATE_HI:`ECD_STATE_LO] <= state_next;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          `ECD_ADDR_DW0: dw0_reg <= hwdata;
          `ECD_ADDR_DW1: dw1_reg <= hwdata;
          `ECD_ADDR_CTRL: ctrl_reg <= hwdata[1:0];
          `ECD_ADDR_STREAM: stream_reg <= hwdata[15:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // Stream and kind decoding into registered outputs.
  always @(posedge sys_clk) begin
    if (reset) begin
      streams_enabled <= 1'b0;
      stream_id_width <= 5'h00;
      primary_index_width <= 5'h00;
      primary_index <= 16'h0000;
      secondary_index <= 16'h0000;
      primary_entries <= 17'h0_0000;
      endpoint_state_field <= `ECD_ST_DISABLED;
      endpoint_kind <= `ECD_KIND_INVALID;
      context_valid <= 1'b0;
      config_error <= 1'b0;
      service_interval_payload_high <= 8'h00;
    end else if (clk_en) begin
      endpoint_state_field <= dw0_reg[`ECD_STATE_HI:`ECD_STATE_LO];
      endpoint_kind <= kind_raw;
      context_valid <= (kind_raw != `ECD_KIND_INVALID) &&
        (kind_raw <= `ECD_KIND_ISO_IN);
      service_interval_payload_high <= large_service_interval_capability ?
        dw0_reg[`ECD_PLHI_HI:`ECD_PLHI_LO] : 8'h00;
      if (pstr_exp == 5'h00) begin
        streams_enabled <= 1'b0;
        stream_id_width <= 5'h00;
        primary_index_width <= 5'h00;
        primary_index <= 16'h0000;
        secondary_index <= 16'h0000;
        primary_entries <= 17'h0_0000;
        config_error <= 1'b0;
      end else begin
        streams_enabled <= 1'b1;
        stream_id_width <= pstr_exp + 5'h01;
        primary_entries <= 17'h0_0001 << (pstr_exp + 5'h01);
        if (lsa_flag) begin
          primary_index_width <= pstr_exp + 5'h01;
          primary_index <= stream_reg;
          secondary_index <= 16'h0000;
          config_error <= pstr_exp > `ECD_LINEAR_MAX_EXP;
        end else begin
          primary_index_width <= pstr_exp + 5'h01;
          primary_index <= stream_reg &
            ((16'h0001 << (pstr_exp + 5'h01)) - 16'h0001);
          secondary_index <= stream_reg >> (pstr_exp + 5'h01);
          config_error <= pstr_exp > `ECD_SPLIT_MAX_EXP;
        end
      end
    end
  end

  ecd_interval_timer #(
    .BASE_CYC(BASE_CYC)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .enable(endpoint_state_field == `ECD_ST_RUNNING),
    .interval(interval),
    .tick(service_tick),
    .slot_count(slot_count)
  );

  // The burst multiplier field is stored but never checked against
  // the burst size. Reserved-zero bits are stored and never decoded.

endmodule

// ---- testbench/ecd_top_sva.sv ----
`timescale 1ns/1ps
// Relations among the decoded outputs and the abort pulse.
module ecd_top_sva #(
  parameter BASE_CYC = 4
) (
  // Clock and reset.
  input wire sys_clk,
  input wire reset,
  // Watched signals.
  input wire txn_fail,
  input wire streams_enabled,
  input wire [4:0] stream_id_width,
  input wire [15:0] primary_index,
  input wire [15:0] secondary_index,
  input wire [16:0] primary_entries,
  input wire [2:0] endpoint_state_field,
  input wire [2:0] endpoint_kind,
  input wire context_valid,
  input wire config_error,
  input wire service_tick,
  input wire trb_abort,
  input wire transaction_error_event
);
  default clocking dck @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_NO_STREAMS: assert property (!streams_enabled |->
    stream_id_width == 5'h00 && primary_entries == 17'h0_0000)
    else $error("sizes not zero without streams");
  AST_ENTRIES: assert property (streams_enabled |->
    primary_entries == (17'h0_0001 << stream_id_width))
    else $error("entries not two to the id width");
  AST_SPLIT_INDEX: assert property (
    streams_enabled && secondary_index != 16'h0000 |->
    primary_index < primary_entries)
    else $error("split primary index out of range");
  AST_CFG_ERR: assert property (config_error |->
    streams_enabled && stream_id_width > 5'h08)
    else $error("config error with small exponent");
  AST_VALID: assert property (context_valid ==
    (endpoint_kind >= 3'h1 && endpoint_kind <= 3'h5))
    else $error("validity does not match kind");
  AST_STATE_CODE: assert property (endpoint_state_field <= 3'h4)
    else $error("reserved state code");
  AST_ABORT_EVENT: assert property (
    trb_abort == transaction_error_event)
    else $error("abort and event differ");
  AST_ABORT_CAUSE: assert property (
    trb_abort |-> $past(txn_fail) ##1 !trb_abort)
    else $error("abort without failure or too long");
  AST_HALT: assert property (
    trb_abort |-> ##[0:1] endpoint_state_field == 3'h2)
    else $error("abort did not halt");
  // Holds because the shortest period is BASE_CYC, at least four.
  AST_TICK_GAP: assert property (
    service_tick |=> !service_tick [*3])
    else $error("service ticks too close");
endmodule

bind ecd_top ecd_top_sva #(.BASE_CYC(BASE_CYC)) chk_u (
  .sys_clk(sys_clk),
  .reset(reset),
  .txn_fail(txn_fail),
  .streams_enabled(streams_enabled),
  .stream_id_width(stream_id_width),
  .primary_index(primary_index),
  .secondary_index(secondary_index),
  .primary_entries(primary_entries),
  .endpoint_state_field(endpoint_state_field),
  .endpoint_kind(endpoint_kind),
  .context_valid(context_valid),
  .config_error(config_error),
  .service_tick(service_tick),
  .trb_abort(trb_abort),
  .transaction_error_event(transaction_error_event)
);

// ---- testbench/ecd_top_test.sv ----
`timescale 1ns/1ps
`include "ecd_defines.vh"
// Self-checking bench for the endpoint context decoder.
module ecd_top_test;
  localparam BASE = 4;
  reg sys_clk, reset, hsel, hwrite, txn_start, txn_fail, ce;
  reg [11:0] haddr;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [31:0] hwdata, seed, rd, rv;
  reg [15:0] sid;
  reg [7:0] pl;
  wire hreadyout, hresp, streams_enabled, context_valid, config_error;
  wire service_tick, trb_abort, transaction_error_event;
  wire [31:0] hrdata;
  wire [4:0] stream_id_width, primary_index_width;
  wire [15:0] primary_index, secondary_index;
  wire [16:0] primary_entries;
  wire [2:0] endpoint_state_field, endpoint_kind;
  wire [7:0] service_interval_payload_high;
  integer mismatches, tests_run, cycles, aborts, e, l, k, n, a0;

  // The short base period keeps the service ticks quick to measure.
  ecd_top #(.BASE_CYC(BASE)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .clk_en(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .txn_start(txn_start),
    .txn_fail(txn_fail), .txn_ok(1'b0),
    .streams_enabled(streams_enabled), .stream_id_width(stream_id_width),
    .primary_index_width(primary_index_width),
    .primary_index(primary_index), .secondary_index(secondary_index),
    .primary_entries(primary_entries),
    .endpoint_state_field(endpoint_state_field),
    .endpoint_kind(endpoint_kind), .context_valid(context_valid),
    .config_error(config_error),
    .service_interval_payload_high(service_interval_payload_high),
    .service_tick(service_tick), .trb_abort(trb_abort),
    .transaction_error_event(transaction_error_event));

  // Free-running clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Cycle limit against hangs; abort pulses are tallied mid-cycle,
  // where the registered pulse has settled.
  always @(negedge sys_clk) begin
    cycles = cycles + 1;
    if (trb_abort === 1'b1) aborts = aborts + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== x) begin
      mismatches = mismatches + 1;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One single transfer; the address phase holds until ready is seen.
  task ahb(input [11:0] a, input w, input [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // Clearing run first lets a fresh context start from disabled.
  task go_run(input [7:0] iv);
    ahb(`ECD_ADDR_CTRL, 1, 32'h0000_0000);
    ahb(`ECD_ADDR_DW0, 1, {8'h00, iv, 16'h0000});
    ahb(`ECD_ADDR_CTRL, 1, 32'h0000_0002);
    settle();
  endtask

  task txn(input s, input f);
    @(posedge sys_clk);
    txn_start <= s;
    txn_fail <= f;
    @(posedge sys_clk);
    txn_start <= 1'b0;
    txn_fail <= 1'b0;
  endtask

  task wait_tick();
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n = n + 1;
    end while (service_tick !== 1'b1 && n < 100);
  endtask

  task complete_run();
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence.
  initial begin
    {hsel, hwrite, txn_start, txn_fail, haddr, htrans, hwdata} = 0;
    ce = 1'b1;
    {mismatches, tests_run, cycles, aborts} = 0;
    hsize = 3'b010;
    seed = 32'h0000_6E06;
    reset = 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    ahb(`ECD_ADDR_STATUS, 0, 0);
    chk("status", 0, rd);
    for (e = 0; e < 16; e = e + 1) begin
      for (l = 0; l < 2; l = l + 1) begin
        sid = rnd();
        pl = rnd();
        rv = rnd();
        ahb(`ECD_ADDR_CTRL, 1, l);
        ahb(`ECD_ADDR_STREAM, 1, {16'h0000, sid});
        // flag zero with no streams, byte zero without capability
        // bulk kind, zero retry limit; split exponents above 7 expect a config error
        ahb(`ECD_ADDR_DW0, 1, {(l ? pl : 8'h00), 8'h00, l[0] && e != 0,
          e[4:0], 7'h00, 3'h0});
        ahb(`ECD_ADDR_DW1, 1, {26'h000_0000, 3'h2, 2'b00, rv[0]});
        settle();
        chk("streams", e != 0, streams_enabled);
        chk("id_width", e ? e + 1 : 0, stream_id_width);
        chk("idx_width", e ? e + 1 : 0, primary_index_width);
        chk("entries", e ? 1 << (e + 1) : 0, primary_entries);
        chk("cfg_err", !l && e > 7, config_error);
        chk("pl_high", l ? pl : 0, service_interval_payload_high);
        if (e) begin
          chk("p_idx", l ? sid : sid % (1 << (e + 1)), primary_index);
          chk("s_idx", l ? 0 : sid >> (e + 1), secondary_index);
        end
      end
    end
    ahb(`ECD_ADDR_ARRAY, 0, 0);
    chk("array", {10'h000, 5'h10, 17'h1_0000}, rd);
    // all kinds, bulk included, get a zero exponent first
    ahb(`ECD_ADDR_DW0, 1, 32'h0000_0000);
    for (k = 0; k < 8; k = k + 1) begin
      // limit stays zero for every kind
      ahb(`ECD_ADDR_DW1, 1, {26'h000_0000, k[2:0], 3'h0});
      settle();
      chk("kind", k, endpoint_kind);
      chk("valid", k > 0 && k < 6, context_valid);
    end
    ahb(12'h01C, 1, rnd());
    ahb(12'h01C, 0, 0);
    chk("unmapped", 0, rd);
    chk("hresp", 0, hresp);
    // A write issued while the enable is low must leave no trace.
    ahb(`ECD_ADDR_STREAM, 1, 32'h0000_1234);
    ce <= 1'b0;
    ahb(`ECD_ADDR_STREAM, 1, 32'h0000_5678);
    ce <= 1'b1;
    ahb(`ECD_ADDR_STREAM, 0, 0);
    chk("freeze", 32'h0000_1234, rd);
    ahb(`ECD_ADDR_DW1, 1, 32'h0000_0010);
    go_run(8'h00);
    chk("state", `ECD_ST_RUNNING, endpoint_state_field);
    ahb(`ECD_ADDR_CTRL, 1, 32'h0000_0000);
    settle();
    chk("state", `ECD_ST_STOPPED, endpoint_state_field);
    for (k = 0; k < 3; k = k + 1) begin
      go_run(k[7:0]);
      wait_tick();
      wait_tick();
      chk("period", BASE << k, n);
    end
    // Limits 0 to 3; for limits 2 and 3 a reload must restore the count before it runs out.
    for (k = 0; k < 4; k = k + 1) begin
      ahb(`ECD_ADDR_DW1, 1, {26'h000_0000, 3'h2, k[1:0], 1'b0});
      go_run(8'h00);
      a0 = aborts;
      txn(1, 1);
      if (k > 1) begin
        txn(1, 1);
        settle();
        chk("reload", a0, aborts);
      end
      for (n = 1; n < (k ? k : 4); n = n + 1) txn(0, 1);
      settle();
      chk("aborts", a0 + (k != 0), aborts);
      chk("state", k ? 2 : 1, endpoint_state_field);
    end
    complete_run();
  end
endmodule
